// ### include/dmsw_pkg.sv
// Register map, mode codes, timing and bus carriers of the drive mode switch block
// Function
// [RULE_01] In Operation Enabled, control starts the moment a new mode is selected.
// [RULE_02] Outside Operation Enabled, mode is stored; control starts on reaching Operation Enabled.
// [RULE_03] Analog and voltage modes take their set-point straight from the source at start.
// [RULE_04] Cyclic modes start at zero or current position; no set-point loaded before start.
// [RULE_05] Profile velocity starts at zero speed, profile position at current position.
// [RULE_06] Local position control: gearing/step use current position, analog source uses analog value.
// [RULE_07] Option bit 0 clear: keep set-points; PP/PV wait for a first new set-point.
// [RULE_08] Option bit 0 set: reset torque/speed to zero, position to actual on change.
// [RULE_09] Option bit 1 clear: position limits only clamp the commanded target position.
// [RULE_10] Option bit 1 set: limits act as switches in velocity/torque modes, stopping drive.
// [RULE_11] Option bit 2 clear: after controller start the drive sits in Switch On Disabled.
// [RULE_12] Option bit 2 set: after controller start the drive goes to Operation Enabled.
// [RULE_13] Option bit 3 clear: relative moves, immediate too, add to last set-point.
// [RULE_14] Option bit 3 set: immediate relative moves add to the actual position.
// [RULE_15] Option bit 4 set: ignore position limits in homing; clear: apply if bit 1.
// [RULE_16] Option bit 5 set: homing uses homing torque limits, else normal torque limits.
// [RULE_17] PP target comes from target position register, absolute or relative distance.
// [RULE_18] A PP move starts on a rising edge of controlword bit 4, never on level.
// [RULE_19] At move start the profile is fixed from current parameters, then issued stepwise.
// [RULE_20] Profile speed feedforward reaches the loop only when configured on.
// [RULE_21] Target reached shows only after position window time elapses inside the window.
// [RULE_22] Mode codes are signed 8-bit: -4,-3,-2,-1,0,1,3,6,8,9,10.
// [RULE_23] Controlword bit 6 selects absolute (0) or relative (1) target in PP.
// [RULE_24] Option bits 6 to 15 are stored and read back but have no effect.
package dmsw_pkg;
   // Register indices; byte address is four times the index
   localparam logic [13:0] IDX_CW = 14'h0000;
   localparam logic [13:0] IDX_DRV = 14'h0001;
   localparam logic [13:0] IDX_MODE = 14'h0002;
   localparam logic [13:0] IDX_TPOS = 14'h0003;
   localparam logic [13:0] IDX_TVEL = 14'h0004;
   localparam logic [13:0] IDX_TTRQ = 14'h0005;
   localparam logic [13:0] IDX_LMIN = 14'h0006;
   localparam logic [13:0] IDX_LMAX = 14'h0007;
   localparam logic [13:0] IDX_STEP = 14'h0008;
   localparam logic [13:0] IDX_WIN = 14'h0009;
   localparam logic [13:0] IDX_WTIME = 14'h000A;
   localparam logic [13:0] IDX_TLIM = 14'h000B;
   localparam logic [13:0] IDX_HLIM = 14'h000C;
   localparam logic [13:0] IDX_CFG = 14'h000D;
   localparam logic [13:0] IDX_STAT = 14'h0010;
   localparam logic [13:0] IDX_SPOS = 14'h0011;
   localparam logic [13:0] IDX_OPTS = 14'h233F;
   // Reset values
   localparam logic [15:0] OPTS_RST = 16'h0001;
   localparam logic [31:0] TLIM_RST = 32'h1770_1770;
   localparam logic [31:0] HLIM_RST = 32'h03E8_03E8;
   localparam logic [31:0] LMIN_RST = 32'h8000_0000;
   localparam logic [31:0] LMAX_RST = 32'h7FFF_FFFF;
   localparam logic [31:0] STEP_RST = 32'h0000_0001;
   localparam logic [31:0] WIN_RST = 32'h0000_0010;
   localparam logic [15:0] WTIME_RST = 16'h0000;
   // Option bit positions
   localparam int OPT_SPRST = 0;
   localparam int OPT_LIMSW = 1;
   localparam int OPT_AUTOEN = 2;
   localparam int OPT_IMMACT = 3;
   localparam int OPT_HIGNLIM = 4;
   localparam int OPT_HTRQ = 5;
   // Controlword and status bit positions
   localparam int CW_NEWSP = 4;
   localparam int CW_IMM = 5;
   localparam int CW_REL = 6;
   localparam int ST_REACHED = 10;
   localparam int ST_SPACK = 12;
   // Mode codes, signed 8-bit
   localparam logic [7:0] MODE_ATC = 8'hFC;
   localparam logic [7:0] MODE_AVC = 8'hFD;
   localparam logic [7:0] MODE_APC = 8'hFE;
   localparam logic [7:0] MODE_VOLT = 8'hFF;
   localparam logic [7:0] MODE_OFF = 8'h00;
   localparam logic [7:0] MODE_PP = 8'h01;
   localparam logic [7:0] MODE_PV = 8'h03;
   localparam logic [7:0] MODE_HOME = 8'h06;
   localparam logic [7:0] MODE_CSP = 8'h08;
   localparam logic [7:0] MODE_CSV = 8'h09;
   localparam logic [7:0] MODE_CST = 8'h0A;
   // Timing: window time counts in milliseconds
   localparam int CLK_NS = 40;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = MS_NS / CLK_NS;
   // Drive state machine
   typedef enum logic [2:0] {
      ST_BOOT = 3'b001,
      ST_DIS = 3'b010,
      ST_EN = 3'b100
   } dmsw_drv_e;
   // Classic Wishbone carriers
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [15:0] adr;
      logic [31:0] dat;
   } dmsw_wb_req_s;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } dmsw_wb_rsp_s;
endpackage

// ### hw/dmsw_top.sv
// Mode start/switch logic and profile position move start of the drive
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
module dmsw_top
   import dmsw_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register bus
   input dmsw_wb_req_s wb_i,
   output dmsw_wb_rsp_s wb_o,
   // Feedback and local set-point source
   input wire logic [31:0] act_pos,
   input wire logic [31:0] analog_sp,
   input wire logic src_analog,
   // Control outputs
   output logic power_en,
   output logic ctrl_run,
   output logic [31:0] sp_pos,
   output logic [31:0] sp_vel,
   output logic [15:0] sp_trq,
   output logic [15:0] sp_vlt,
   output logic [31:0] ff_vel,
   output logic [15:0] trq_lim_pos,
   output logic [15:0] trq_lim_neg,
   output logic limit_stop,
   output logic target_reached
);
   typedef struct packed {
      dmsw_drv_e dst;
      logic ack;
      logic [31:0] rdat;
      logic [15:0] cw;
      logic newsp_prev;
      logic [7:0] mode;
      logic [31:0] tpos;
      logic [31:0] tvel;
      logic [15:0] ttrq;
      logic [31:0] lmin;
      logic [31:0] lmax;
      logic [31:0] step;
      logic [31:0] win;
      logic [15:0] wtime;
      logic [31:0] tlim;
      logic [31:0] hlim;
      logic ff_en;
      logic [15:0] opts;
      logic run;
      logic pend;
      logic moving;
      logic [31:0] pp_tgt;
      logic [31:0] pp_step;
      logic [31:0] sp_pos;
      logic [31:0] sp_vel;
      logic [15:0] sp_trq;
      logic [15:0] sp_vlt;
      logic [31:0] ff_vel;
      logic stop;
      logic reached;
      logic sp_ack;
      logic [15:0] ms_cnt;
      logic [15:0] win_cnt;
      logic [31:0] tlim_out;
   } dmsw_state_s;

   dmsw_state_s s, n;
   logic acc, wr, mode_wr, sp_wr, start, lim_act, outside, in_win;
   logic [13:0] idx;
   logic [31:0] rv, wd, base, tgt, diff;

   // Signed clamp into the software position window
   function automatic logic [31:0] clamp(input logic [31:0] v, lo, hi);
      if ($signed(v) < $signed(lo))
         return lo;
      else if ($signed(v) > $signed(hi))
         return hi;
      return v;
   endfunction

   // Byte-lane merge of a write into the stored value
   function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] sel);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
         if (sel[i])
            r[8*i +: 8] = d[8*i +: 8];
      return r;
   endfunction

   // Read-back multiplexer
   always_comb
   begin
      idx = wb_i.adr[15:2];
      case (idx)
         IDX_CW: rv = {16'h0000, s.cw};
         IDX_DRV: rv = {31'h0000_0000, s.dst == ST_EN};
         IDX_MODE: rv = {24'h00_0000, s.mode};
         IDX_TPOS: rv = s.tpos;
         IDX_TVEL: rv = s.tvel;
         IDX_TTRQ: rv = {16'h0000, s.ttrq};
         IDX_LMIN: rv = s.lmin;
         IDX_LMAX: rv = s.lmax;
         IDX_STEP: rv = s.step;
         IDX_WIN: rv = s.win;
         IDX_WTIME: rv = {16'h0000, s.wtime};
         IDX_TLIM: rv = s.tlim;
         IDX_HLIM: rv = s.hlim;
         IDX_CFG: rv = {31'h0000_0000, s.ff_en};
         IDX_STAT: rv = {19'h0_0000, s.sp_ack, 1'b0, s.reached, 5'h00, s.moving, s.pend,
                         s.stop, s.run, s.dst == ST_EN};
         IDX_SPOS: rv = s.sp_pos;
         IDX_OPTS: rv = {16'h0000, s.opts}; // RULE_24
         default: rv = 32'h0000_0000;
      endcase
   end

   // Next-state logic
   always_comb
   begin
      n = s;
      acc = wb_i.cyc & wb_i.stb & s.ack;
      wr = acc & wb_i.we;
      wd = merge(rv, wb_i.dat, wb_i.sel);
      mode_wr = 1'b0;
      sp_wr = 1'b0;
      base = 32'h0000_0000;
      tgt = 32'h0000_0000;
      diff = 32'h0000_0000;
      n.ack = wb_i.cyc & wb_i.stb & ~s.ack;
      n.rdat = n.ack ? rv : s.rdat;
      // Register writes take effect at the acknowledge edge
      if (wr)
      begin
         case (idx)
            IDX_CW: n.cw = wd[15:0];
            IDX_DRV: n.dst = wd[0] ? ST_EN : ST_DIS;
            IDX_MODE:
            begin
               n.mode = wd[7:0]; // RULE_22
               mode_wr = 1'b1;
            end
            IDX_TPOS:
            begin
               n.tpos = wd;
               sp_wr = 1'b1;
            end
            IDX_TVEL:
            begin
               n.tvel = wd;
               sp_wr = 1'b1;
            end
            IDX_TTRQ:
            begin
               n.ttrq = wd[15:0];
               sp_wr = 1'b1;
            end
            IDX_LMIN: n.lmin = wd;
            IDX_LMAX: n.lmax = wd;
            IDX_STEP: n.step = wd;
            IDX_WIN: n.win = wd;
            IDX_WTIME: n.wtime = wd[15:0];
            IDX_TLIM: n.tlim = wd;
            IDX_HLIM: n.hlim = wd;
            IDX_CFG: n.ff_en = wd[0];
            IDX_OPTS: n.opts = wd[15:0];
            default: ;
         endcase
      end
      // Controller start picks the drive state from the options
      if (s.dst == ST_BOOT)
         n.dst = s.opts[OPT_AUTOEN] ? ST_EN : ST_DIS; // RULE_11 RULE_12
      start = ((s.dst == ST_EN) & mode_wr) | ((s.dst != ST_EN) & (n.dst == ST_EN)); // RULE_01 RULE_02
      if (n.dst != ST_EN)
      begin
         n.run = 1'b0; // RULE_02
         n.reached = 1'b0;
         n.pend = 1'b0;
         n.moving = 1'b0;
      end
      else if (start)
      begin
         n.run = 1'b1;
         n.pend = 1'b0;
         n.moving = 1'b0;
         n.reached = 1'b0;
         unique case (n.mode)
            MODE_APC: n.sp_pos = src_analog ? analog_sp : act_pos; // RULE_03 RULE_06
            MODE_AVC: n.sp_vel = analog_sp; // RULE_03
            MODE_ATC: n.sp_trq = analog_sp[15:0]; // RULE_03
            MODE_VOLT: n.sp_vlt = analog_sp[15:0]; // RULE_03
            MODE_CSP: n.sp_pos = s.opts[OPT_SPRST] ? act_pos : n.tpos; // RULE_04 RULE_07 RULE_08
            MODE_CSV: n.sp_vel = s.opts[OPT_SPRST] ? 32'h0000_0000 : n.tvel; // RULE_04 RULE_07
            MODE_CST: n.sp_trq = s.opts[OPT_SPRST] ? 16'h0000 : n.ttrq; // RULE_04 RULE_08
            MODE_PP, MODE_PV:
            begin
               // Without reset the mode is entered on the first new set-point
               n.run = s.opts[OPT_SPRST]; // RULE_07
               n.pend = ~s.opts[OPT_SPRST];
               n.sp_pos = act_pos; // RULE_05 RULE_08
               n.sp_vel = 32'h0000_0000; // RULE_05
            end
            MODE_HOME: n.sp_vel = 32'h0000_0000;
            default: n.run = 1'b0;
         endcase
      end
      else if (s.pend & sp_wr)
      begin
         n.pend = 1'b0; // RULE_07
         n.run = 1'b1;
         if (s.mode == MODE_PV)
            n.sp_vel = n.tvel;
      end
      else if (s.run)
      begin
         // Track the source; cyclic set-points load only while running
         case (s.mode)
            MODE_APC: n.sp_pos = src_analog ? analog_sp : s.sp_pos; // RULE_06
            MODE_AVC: n.sp_vel = analog_sp;
            MODE_ATC: n.sp_trq = analog_sp[15:0];
            MODE_VOLT: n.sp_vlt = analog_sp[15:0];
            MODE_CSP: n.sp_pos = sp_wr ? n.tpos : s.sp_pos; // RULE_04
            MODE_CSV, MODE_PV: n.sp_vel = sp_wr ? n.tvel : s.sp_vel;
            MODE_CST: n.sp_trq = sp_wr ? n.ttrq : s.sp_trq;
            default: ;
         endcase
      end
      // Profile position move start on the bit 4 edge
      n.newsp_prev = s.cw[CW_NEWSP];
      // A mode start or disable in the same cycle takes priority over the move
      if (~start & s.run & n.run & (s.mode == MODE_PP) & s.cw[CW_NEWSP] & ~s.newsp_prev) // RULE_18
      begin
         base = (s.cw[CW_IMM] & s.opts[OPT_IMMACT]) ? act_pos : s.pp_tgt; // RULE_13 RULE_14
         tgt = s.cw[CW_REL] ? base + s.tpos : s.tpos; // RULE_17 RULE_23
         n.pp_tgt = clamp(tgt, s.lmin, s.lmax); // RULE_09
         n.pp_step = s.step; // RULE_19
         n.moving = 1'b1;
         n.reached = 1'b0;
         n.sp_ack = 1'b1;
         n.win_cnt = 16'h0000;
      end
      else if (s.moving & s.run & n.run & ~start)
      begin
         // Issue the demand stepwise toward the latched target
         diff = s.pp_tgt - s.sp_pos; // RULE_19
         if (($signed(diff) <= $signed(s.pp_step)) && ($signed(diff) >= -$signed(s.pp_step)))
         begin
            n.sp_pos = s.pp_tgt;
            n.moving = 1'b0;
            n.ff_vel = 32'h0000_0000;
         end
         else
         begin
            n.sp_pos = $signed(diff) > 0 ? s.sp_pos + s.pp_step : s.sp_pos - s.pp_step;
            n.ff_vel = !s.ff_en ? 32'h0000_0000 :
                       $signed(diff) > 0 ? s.pp_step : -s.pp_step; // RULE_20
         end
      end
      if (~s.cw[CW_NEWSP])
         n.sp_ack = 1'b0;
      // Target reached after the window time spent inside the window
      diff = act_pos - s.pp_tgt;
      in_win = ($signed(diff) <= $signed(s.win)) && ($signed(diff) >= -$signed(s.win));
      n.ms_cnt = (s.ms_cnt >= 16'(MS_CYCLES - 1)) ? 16'h0000 : s.ms_cnt + 16'h0001;
      if (!(s.run & (s.mode == MODE_PP) & ~s.moving & in_win))
         n.win_cnt = 16'h0000;
      else if (s.win_cnt >= s.wtime)
         n.reached = ~n.moving; // RULE_21
      else if (s.ms_cnt == 16'h0000)
         n.win_cnt = s.win_cnt + 16'h0001;
      // Position limits as switches in velocity, torque and homing modes
      lim_act = s.opts[OPT_LIMSW] & ((s.mode == MODE_PV) | (s.mode == MODE_CSV) |
                (s.mode == MODE_CST) | (s.mode == MODE_AVC) | (s.mode == MODE_ATC) |
                ((s.mode == MODE_HOME) & ~s.opts[OPT_HIGNLIM])); // RULE_10 RULE_15
      outside = ($signed(act_pos) < $signed(s.lmin)) | ($signed(act_pos) > $signed(s.lmax));
      n.stop = lim_act & outside & s.run; // RULE_10
      if (n.stop)
      begin
         n.sp_vel = 32'h0000_0000;
         n.sp_trq = 16'h0000;
      end
      // Torque limit selection
      n.tlim_out = ((s.mode == MODE_HOME) & s.opts[OPT_HTRQ]) ? s.hlim : s.tlim; // RULE_16
   end

   // State register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
         s.dst <= ST_BOOT;
         s.opts <= OPTS_RST;
         s.tlim <= TLIM_RST;
         s.hlim <= HLIM_RST;
         s.tlim_out <= TLIM_RST;
         s.lmin <= LMIN_RST;
         s.lmax <= LMAX_RST;
         s.step <= STEP_RST;
         s.win <= WIN_RST;
         s.wtime <= WTIME_RST;
      end
      else
         s <= n;
   end

   // Outputs
   assign wb_o.ack = s.ack;
   assign wb_o.dat = s.rdat;
   assign power_en = s.dst == ST_EN;
   assign ctrl_run = s.run;
   assign sp_pos = s.sp_pos;
   assign sp_vel = s.sp_vel;
   assign sp_trq = s.sp_trq;
   assign sp_vlt = s.sp_vlt;
   assign ff_vel = s.ff_vel;
   assign trq_lim_pos = s.tlim_out[15:0];
   assign trq_lim_neg = s.tlim_out[31:16];
   assign limit_stop = s.stop;
   assign target_reached = s.reached;

   // Checks
   property p_ack_pulse; // Wishbone acknowledge, the implementer's choice
      @(posedge clk) disable iff (rst) s.ack |=> !s.ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles"); // Wishbone acknowledge, the implementer's choice
   property p_mode_start;
      @(posedge clk) disable iff (rst)
         power_en && wr && idx == IDX_MODE && wd[7:0] == MODE_CSP |=> ctrl_run;
   endproperty
   a_mode_start: assert property (p_mode_start) else $error("no control on mode select"); // RULE_01
   property p_boot_dis;
      @(posedge clk) disable iff (rst) (s.dst == ST_BOOT) && !s.opts[OPT_AUTOEN] |=> !power_en;
   endproperty
   a_boot_dis: assert property (p_boot_dis) else $error("boot did not disable"); // RULE_11
   property p_boot_en;
      @(posedge clk) disable iff (rst) (s.dst == ST_BOOT) && s.opts[OPT_AUTOEN] |=> power_en;
   endproperty
   a_boot_en: assert property (p_boot_en) else $error("auto enable failed"); // RULE_12
   property p_no_run_dis;
      @(posedge clk) disable iff (rst) !power_en |-> !ctrl_run && !s.moving;
   endproperty
   a_no_run_dis: assert property (p_no_run_dis) else $error("run while disabled"); // RULE_02
   property p_csv_reset;
      @(posedge clk) disable iff (rst)
         power_en && wr && idx == IDX_MODE && wd[7:0] == MODE_CSV && s.opts[OPT_SPRST]
         |=> ctrl_run && sp_vel == 32'h0000_0000;
   endproperty
   a_csv_reset: assert property (p_csv_reset) else $error("csv start not zero"); // RULE_08
   property p_csp_keep;
      @(posedge clk) disable iff (rst)
         power_en && wr && idx == IDX_MODE && wd[7:0] == MODE_CSP && !s.opts[OPT_SPRST]
         |=> sp_pos == $past(s.tpos);
   endproperty
   a_csp_keep: assert property (p_csp_keep) else $error("csp lost last set-point"); // RULE_07
   property p_level_no_start;
      @(posedge clk) disable iff (rst)
         !s.moving && s.newsp_prev && s.cw[CW_NEWSP] ##1 !s.cw[CW_NEWSP] |-> !s.moving;
   endproperty
   a_level_no_start: assert property (p_level_no_start) else $error("move on level"); // RULE_18
   property p_reached_still;
      @(posedge clk) disable iff (rst) target_reached |-> !s.moving && ctrl_run;
   endproperty
   a_reached_still: assert property (p_reached_still) else $error("reached while moving"); // RULE_21
   property p_tgt_clamped;
      @(posedge clk) disable iff (rst)
         s.moving |-> $signed(s.pp_tgt) >= $signed(s.lmin) && $signed(s.pp_tgt) <= $signed(s.lmax);
   endproperty
   a_tgt_clamped: assert property (p_tgt_clamped) else $error("target beyond limit"); // RULE_09
   property p_home_trq;
      @(posedge clk) disable iff (rst)
         s.mode == MODE_HOME && s.opts[OPT_HTRQ] ##1 $stable(s.hlim) |-> trq_lim_pos == s.hlim[15:0];
   endproperty
   a_home_trq: assert property (p_home_trq) else $error("homing torque limit unused"); // RULE_16
endmodule

// ### tb/dmsw_master_model.sv
// Bus master and simple plant standing in for the motion master
`timescale 1ns/1ps
module dmsw_master_model
   import dmsw_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register bus
   output dmsw_wb_req_s wb_i,
   input dmsw_wb_rsp_s wb_o,
   // Plant
   input wire logic [31:0] sp_pos,
   input wire logic track,
   input wire logic [31:0] pos_set,
   output logic [31:0] act_pos
);
   // Idle bus and plant at time zero
   initial
   begin
      wb_i = '0;
      act_pos = '0;
   end
   // Plant follows the set-point when tracking, else a fixed position
   always @(posedge clk)
   begin
      act_pos <= track ? sp_pos : pos_set;
   end
   // One classic cycle, held until ack is sampled high
   task automatic xfer(input logic w, input logic [13:0] i, input logic [31:0] d,
      output logic [31:0] q);
      wb_i.cyc <= 1'b1;
      wb_i.stb <= 1'b1;
      wb_i.we <= w;
      wb_i.sel <= 4'hF;
      wb_i.adr <= {i, 2'b00};
      wb_i.dat <= d;
      @(posedge clk);
      // Wait for the answer; only the bench timeout ends a hang
      while (wb_o.ack !== 1'b1)
         @(posedge clk);
      q = wb_o.dat;
      wb_i.cyc <= 1'b0;
      wb_i.stb <= 1'b0;
      wb_i.we <= 1'b0;
      @(posedge clk);
   endtask
endmodule

// ### tb/dmsw_test.sv
// Register-level testbench of the mode switch and move start block
`timescale 1ns/1ps
module dmsw_test
   import dmsw_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   dmsw_wb_req_s wb_i;
   dmsw_wb_rsp_s wb_o;
   logic [31:0] act_pos, pos_set, sp_pos, sp_vel, ff_vel, q, got;
   logic [31:0] analog_sp = 32'h0000_0ABC;
   logic src_analog = 1'b1;
   logic track = 1'b0;
   logic power_en, ctrl_run, limit_stop, target_reached;
   logic [15:0] sp_trq, sp_vlt, trq_lim_pos, trq_lim_neg;
   logic [7:0] am [4] = '{MODE_ATC, MODE_AVC, MODE_APC, MODE_VOLT};
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;

   dmsw_top #(.MS_CYCLES(4)) dut (.clk(clk), .rst(rst), .wb_i(wb_i), .wb_o(wb_o),
      .act_pos(act_pos), .analog_sp(analog_sp), .src_analog(src_analog),
      .power_en(power_en), .ctrl_run(ctrl_run), .sp_pos(sp_pos), .sp_vel(sp_vel),
      .sp_trq(sp_trq), .sp_vlt(sp_vlt), .ff_vel(ff_vel), .trq_lim_pos(trq_lim_pos),
      .trq_lim_neg(trq_lim_neg), .limit_stop(limit_stop),
      .target_reached(target_reached));
   dmsw_master_model m (.clk(clk), .wb_i(wb_i), .wb_o(wb_o), .sp_pos(sp_pos),
      .track(track), .pos_set(pos_set), .act_pos(act_pos));

   // Clock and hang guard
   always #20 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         wrap_up();
      end
   end

   // Verdict
   task wrap_up();
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Compare seen against expected
   task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   // Register access helpers
   task wr(input logic [13:0] i, input logic [31:0] d);
      m.xfer(1'b1, i, d, q);
   endtask
   task rd(input logic [13:0] i);
      m.xfer(1'b0, i, 32'h0000_0000, q);
   endtask
   task settle();
      repeat (2) @(posedge clk);
   endtask
   // Bounded wait for the position set-point
   task wait_pos(input logic [31:0] t);
      int n;
      n = 0;
      while (sp_pos !== t && n < 400)
      begin
         @(posedge clk);
         n++;
      end
   endtask

   // Main sequence
   initial
   begin
      pos_set = 32'h0000_1234;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(IDX_OPTS);
      check(q, {16'h0000, OPTS_RST}, "opts reset");
      rd(IDX_TLIM);
      check(q, TLIM_RST, "tlim reset");
      check(power_en, 1'b0, "disabled after start");
      wr(14'h0100, 32'hFFFF_FFFF);
      rd(14'h0100);
      check(q, 32'h0000_0000, "unmapped read");
      wr(IDX_OPTS, 32'h0000_FFC1);
      rd(IDX_OPTS);
      check(q, 32'h0000_FFC1, "reserved option bits");
      $display("test registers done");
      wr(IDX_MODE, {24'h0, MODE_CSV});
      settle();
      check(ctrl_run, 1'b0, "no control while disabled");
      wr(IDX_DRV, 32'h0000_0001);
      settle();
      check(ctrl_run, 1'b1, "control on enable");
      check(sp_vel, 32'h0000_0000, "csv starts at zero");
      wr(IDX_MODE, {24'h0, MODE_CSP});
      settle();
      check(sp_pos, pos_set, "csp starts at position");
      $display("test start done");
      for (int k = 0; k < 4; k++)
      begin
         wr(IDX_MODE, {24'h0, am[k]});
         settle();
         got = (k == 0) ? {16'h0, sp_trq} : (k == 1) ? sp_vel :
            (k == 2) ? sp_pos : {16'h0, sp_vlt};
         check(got, (k == 1 || k == 2) ? analog_sp : 32'h0000_0ABC, "analog start");
      end
      src_analog <= 1'b0;
      wr(IDX_MODE, {24'h0, MODE_APC});
      settle();
      check(sp_pos, pos_set, "local source position");
      $display("test analog done");
      wr(IDX_OPTS, 32'h0000_0003);
      wr(IDX_LMAX, 32'h0000_1000);
      wr(IDX_MODE, {24'h0, MODE_CSV});
      settle();
      check(limit_stop, 1'b1, "limit acts as switch");
      wr(IDX_OPTS, 32'h0000_0001);
      settle();
      check(limit_stop, 1'b0, "limit only clamps");
      wr(IDX_OPTS, 32'h0000_0003);
      wr(IDX_MODE, {24'h0, MODE_HOME});
      settle();
      check(limit_stop, 1'b1, "homing honours limits");
      wr(IDX_OPTS, 32'h0000_0013);
      settle();
      check(limit_stop, 1'b0, "homing ignores limits");
      wr(IDX_LMAX, LMAX_RST);
      wr(IDX_OPTS, 32'h0000_0021);
      wr(IDX_MODE, {24'h0, MODE_HOME});
      settle();
      check(trq_lim_pos, HLIM_RST[15:0], "homing torque limit");
      check(trq_lim_neg, HLIM_RST[31:16], "homing negative limit");
      wr(IDX_OPTS, 32'h0000_0001);
      settle();
      check(trq_lim_pos, TLIM_RST[15:0], "normal torque limit");
      check(trq_lim_neg, TLIM_RST[31:16], "normal negative limit");
      $display("test options done");
      wr(IDX_OPTS, 32'h0000_0000);
      wr(IDX_MODE, {24'h0, MODE_PP});
      settle();
      check(ctrl_run, 1'b0, "pp waits for set-point");
      wr(IDX_STEP, 32'h0000_0040);
      wr(IDX_WTIME, 32'h0000_0002);
      wr(IDX_TPOS, 32'h0000_2234);
      settle();
      check(ctrl_run, 1'b1, "pp runs after set-point");
      track <= 1'b1;
      wr(IDX_CW, 32'h0000_0000);
      wr(IDX_CW, 32'h0000_0010);
      wait_pos(32'h0000_2234);
      check(sp_pos, 32'h0000_2234, "absolute move");
      check(target_reached, 1'b0, "window time pending");
      repeat (20) @(posedge clk);
      check(target_reached, 1'b1, "target reached");
      wr(IDX_TPOS, 32'h0000_3000);
      wr(IDX_CW, 32'h0000_0010);
      repeat (20) @(posedge clk);
      check(sp_pos, 32'h0000_2234, "level ignored");
      wr(IDX_TPOS, 32'h0000_0100);
      wr(IDX_CW, 32'h0000_0000);
      wr(IDX_CW, 32'h0000_0050);
      wait_pos(32'h0000_2334);
      check(sp_pos, 32'h0000_2334, "relative move");
      // Plant parked away from the last target, immediate relative move
      track <= 1'b0;
      wr(IDX_CFG, 32'h0000_0001);
      wr(IDX_OPTS, 32'h0000_0008);
      wr(IDX_CW, 32'h0000_0000);
      wr(IDX_CW, 32'h0000_0070);
      settle();
      check(ff_vel, 32'hFFFF_FFC0, "feedforward while moving");
      wait_pos(32'h0000_1334);
      check(sp_pos, 32'h0000_1334, "immediate move from actual");
      check(ff_vel, 32'h0000_0000, "feedforward cleared");
      $display("test profile move done");
      wrap_up();
   end
endmodule
